// ==== verilog/mpl_map.svh ====
// constants for the maintenance panel channel logic
`ifndef MPL_MAP_SVH
`define MPL_MAP_SVH
`define MPL_DATA_W 30
`define MPL_NUM_IN 3
`define MPL_NUM_OUT 3
`define MPL_PULSE_NS 16
`define MPL_CLK_NS 4
`define MPL_PULSE_CYC ((`MPL_PULSE_NS + `MPL_CLK_NS - 1) / `MPL_CLK_NS)
`define MPL_SEL_W 2
`endif

// ==== verilog/mpl_pkg.sv ====
// types for the maintenance panel channel logic
`include "mpl_map.svh"
package mpl_pkg;
	typedef enum logic [2:0] {
		MPL_ONLINE = 3'h1,
		MPL_OFF_IN = 3'h2,
		MPL_OFF_OUT = 3'h4
	} mpl_mode_t;
	typedef struct packed {
		logic ack;
		logic int_enable;
	} mpl_in_ctl_t;
	typedef struct packed {
		logic out_ack;
		logic cmd_strobe;
	} mpl_out_ctl_t;
	typedef struct packed {
		logic out_req;
		logic cmd_req;
	} mpl_out_req_t;
endpackage

// ==== verilog/mpl_channel.sv ====
// maintenance panel logic: data buffering, monitoring and off-line simulation
//
// How it works
// - buffer 30 computer data lines to subunits
// - re-drive data to one external peripheral always
// - shared data, independent per-channel control lines
// - lamps show selected input peripheral lines
// - off-line input: block computer control, simulate
// - single step: one pulse per switch press
// - continuous: one pulse per peripheral request
// - lamps show output requests, controls, data
// - off-line output: block data and controls
// - single step output: one pulse per press
// - continuous output: answer each raised request; if both rise together, only the output request
// - operator switches drive all 30 data bits in off-line output, light lamps
// - amplify input acknowledge and interrupt permit
// - simulated pulses match computer pulse width
// - all computer output passes through here
// - supply tolerance change sends power word while input power is good
`timescale 1ns/1ps
`include "mpl_map.svh"
module mpl_channel import mpl_pkg::*; #(
	parameter int DATA_W = `MPL_DATA_W,
	parameter int NUM_IN = `MPL_NUM_IN,
	parameter int NUM_OUT = `MPL_NUM_OUT
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [DATA_W-1:0] cpu_data,
	input wire mpl_out_ctl_t [NUM_OUT-1:0] cpu_out_ctl,
	input wire mpl_in_ctl_t [NUM_IN-1:0] cpu_in_ctl,
	input wire mpl_out_req_t [NUM_OUT-1:0] sub_out_req,
	input wire logic [NUM_IN-1:0] sub_in_req,
	input wire logic [NUM_IN-1:0][DATA_W-1:0] sub_in_data,
	input wire logic offline_in_req,
	input wire logic offline_out_req,
	input wire logic online_req,
	input wire logic [`MPL_SEL_W-1:0] periph_sel,
	input wire logic continuous_mode,
	input wire logic step_switch,
	input wire logic step_cmd,
	input wire logic [DATA_W-1:0] op_switches,
	input wire logic [DATA_W-1:0] supply_ok,
	input wire logic input_power_ok,
	output logic [DATA_W-1:0] sub_data,
	output logic [DATA_W-1:0] ext_data,
	output mpl_out_ctl_t [NUM_OUT-1:0] sub_out_ctl,
	output mpl_in_ctl_t [NUM_IN-1:0] sub_in_ctl,
	output logic [DATA_W-1:0] lamp_data,
	output logic [1:0] lamp_req,
	output logic [1:0] lamp_ctl,
	output logic [DATA_W-1:0] lamp_switch,
	output mpl_mode_t mode,
	output logic power_irq,
	output logic [DATA_W-1:0] power_word
);
	localparam int PW = `MPL_PULSE_CYC;
	localparam int CW = $clog2(PW + 1);

	mpl_mode_t mode_ff;
	logic [`MPL_SEL_W-1:0] sel_ff;
	logic [DATA_W-1:0] sub_data_ff;
	logic [DATA_W-1:0] ext_data_ff;
	logic [DATA_W-1:0] lamp_data_ff;
	logic [DATA_W-1:0] lamp_switch_ff;
	logic [1:0] lamp_req_ff;
	logic [1:0] lamp_ctl_ff;
	logic step_ff;
	logic [NUM_IN-1:0] in_req_ff;
	mpl_out_req_t [NUM_OUT-1:0] out_req_ff;
	logic [CW-1:0] pulse_cnt_ff;
	logic pulse_kind_ff;
	logic [DATA_W-1:0] supply_ff;
	logic supply_seen_ff;
	logic power_irq_ff;
	logic [DATA_W-1:0] power_word_ff;
	logic trig;
	logic trig_kind;
	logic step_rise;
	logic pulse_on;

	function automatic logic rise(input logic now, input logic was);
		return now & ~was;
	endfunction

	// mode selection; a new off-line choice displaces the old
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			mode_ff <= MPL_ONLINE;
			sel_ff <= '0;
		end else if (online_req) begin
			mode_ff <= MPL_ONLINE;
		end else if (offline_in_req && 32'(periph_sel) < NUM_IN) begin
			mode_ff <= MPL_OFF_IN;
			sel_ff <= periph_sel;
		end else if (offline_out_req && 32'(periph_sel) < NUM_OUT) begin
			mode_ff <= MPL_OFF_OUT;
			sel_ff <= periph_sel;
		end
	end
	assign mode = mode_ff;

	// data buffering, shared to subunits and the extra peripheral
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			sub_data_ff <= '0;
			ext_data_ff <= '0;
		end else begin
			ext_data_ff <= cpu_data;
			sub_data_ff <= (mode_ff == MPL_OFF_OUT) ? op_switches : cpu_data;
		end
	end
	assign sub_data = sub_data_ff;
	assign ext_data = ext_data_ff;

	// trigger for simulated pulses
	assign step_rise = rise(step_switch, step_ff);
	always_comb begin
		trig = 1'b0;
		trig_kind = step_cmd;
		unique case (mode_ff)
			MPL_OFF_IN: begin
				if (continuous_mode) begin
					trig = rise(sub_in_req[sel_ff], in_req_ff[sel_ff]);
				end else begin
					trig = step_rise;
				end
			end
			MPL_OFF_OUT: begin
				if (continuous_mode) begin
					trig = rise(sub_out_req[sel_ff].out_req, out_req_ff[sel_ff].out_req) |
						rise(sub_out_req[sel_ff].cmd_req, out_req_ff[sel_ff].cmd_req);
					trig_kind = ~rise(sub_out_req[sel_ff].out_req, out_req_ff[sel_ff].out_req);
				end else begin
					trig = step_rise;
				end
			end
			MPL_ONLINE: begin
				trig = 1'b0;
			end
		endcase
	end

	// fixed-width pulse generator; triggers during a pulse are dropped
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			step_ff <= 1'b0;
			in_req_ff <= '0;
			out_req_ff <= '0;
			pulse_cnt_ff <= '0;
			pulse_kind_ff <= 1'b0;
		end else begin
			step_ff <= step_switch;
			in_req_ff <= sub_in_req;
			out_req_ff <= sub_out_req;
			if (mode_ff == MPL_ONLINE) begin
				pulse_cnt_ff <= '0;
			end else if (pulse_cnt_ff != '0) begin
				pulse_cnt_ff <= pulse_cnt_ff - CW'(1);
			end else if (trig) begin
				pulse_cnt_ff <= CW'(PW);
				pulse_kind_ff <= trig_kind;
			end
		end
	end
	assign pulse_on = pulse_cnt_ff != '0;

	// control routing; only the selected peripheral is simulated
	always_comb begin
		for (int i = 0; i < NUM_IN; i++) begin
			sub_in_ctl[i] = cpu_in_ctl[i];
			if (mode_ff == MPL_OFF_IN && 32'(sel_ff) == i) begin
				sub_in_ctl[i].ack = pulse_on;
				sub_in_ctl[i].int_enable = 1'b1;
			end
		end
		for (int j = 0; j < NUM_OUT; j++) begin
			sub_out_ctl[j] = cpu_out_ctl[j];
			if (mode_ff == MPL_OFF_OUT && 32'(sel_ff) == j) begin
				sub_out_ctl[j].out_ack = pulse_on & ~pulse_kind_ff;
				sub_out_ctl[j].cmd_strobe = pulse_on & pulse_kind_ff;
			end
		end
	end

	// indicator lamps
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			lamp_data_ff <= '0;
			lamp_req_ff <= '0;
			lamp_ctl_ff <= '0;
			lamp_switch_ff <= '0;
		end else begin
			lamp_switch_ff <= op_switches;
			if (mode_ff == MPL_OFF_IN || (32'(periph_sel) < NUM_IN && mode_ff == MPL_ONLINE && !offline_out_req)) begin
				lamp_data_ff <= sub_in_data[sel_ff];
				lamp_req_ff <= {1'b0, sub_in_req[sel_ff]};
				lamp_ctl_ff <= sub_in_ctl[sel_ff];
			end else begin
				lamp_data_ff <= sub_data_ff;
				lamp_req_ff <= sub_out_req[sel_ff];
				lamp_ctl_ff <= sub_out_ctl[sel_ff];
			end
		end
	end
	assign lamp_data = lamp_data_ff;
	assign lamp_req = lamp_req_ff;
	assign lamp_ctl = lamp_ctl_ff;
	assign lamp_switch = lamp_switch_ff;

	// power monitor: one-cycle interrupt on a tolerance change while input_power_ok is high
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			supply_ff <= '0;
			supply_seen_ff <= 1'b0;
			power_irq_ff <= 1'b0;
			power_word_ff <= '0;
		end else begin
			supply_ff <= supply_ok;
			supply_seen_ff <= 1'b1;
			power_irq_ff <= 1'b0;
			if (supply_seen_ff && supply_ok != supply_ff && input_power_ok) begin
				power_irq_ff <= 1'b1;
				power_word_ff <= supply_ok;
			end
		end
	end
	assign power_irq = power_irq_ff;
	assign power_word = power_word_ff;

	sequence s_trig_taken;
		mode_ff != MPL_ONLINE && !pulse_on && trig;
	endsequence

	sequence s_pulse_body;
		pulse_on [*4] ##1 !pulse_on;
	endsequence

	a_pulse_width: assert property (@(posedge clk_sys) disable iff (!rst_n)
		s_trig_taken |=> s_pulse_body)
		else $error("simulated pulse width wrong");
	a_step_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
		mode_ff == MPL_OFF_IN && !continuous_mode && !pulse_on && step_rise |=> pulse_on)
		else $error("step press gave no pulse");
	a_cont_in: assert property (@(posedge clk_sys) disable iff (!rst_n)
		mode_ff == MPL_OFF_IN && continuous_mode && !pulse_on && sub_in_req[sel_ff] && !in_req_ff[sel_ff]
		|=> pulse_on)
		else $error("input request not answered");
	a_ext_data: assert property (@(posedge clk_sys) disable iff (!rst_n)
		1'b1 |=> ext_data == $past(cpu_data))
		else $error("external data not re-driven");
	a_sub_data: assert property (@(posedge clk_sys) disable iff (!rst_n)
		mode_ff != MPL_OFF_OUT |=> mode_ff == MPL_OFF_OUT || sub_data == $past(cpu_data))
		else $error("subunit data not buffered");
	a_off_out_data: assert property (@(posedge clk_sys) disable iff (!rst_n)
		mode_ff == MPL_OFF_OUT && $stable(mode_ff) |=> sub_data == $past(op_switches))
		else $error("operator data not substituted");
	a_offline_block: assert property (@(posedge clk_sys) disable iff (!rst_n)
		mode_ff == MPL_OFF_IN |-> sub_in_ctl[sel_ff].ack == pulse_on)
		else $error("computer control not blocked");
	a_cont_out: assert property (@(posedge clk_sys) disable iff (!rst_n)
		mode_ff == MPL_OFF_OUT && continuous_mode && !pulse_on
		&& rise(sub_out_req[sel_ff].cmd_req, out_req_ff[sel_ff].cmd_req)
		&& !rise(sub_out_req[sel_ff].out_req, out_req_ff[sel_ff].out_req)
		|=> sub_out_ctl[sel_ff].cmd_strobe)
		else $error("command request not strobed");
	a_power_irq: assert property (@(posedge clk_sys) disable iff (!rst_n)
		power_irq |-> $past(input_power_ok) && $past(supply_ok) != $past(supply_ok, 2)
		&& power_word == $past(supply_ok))
		else $error("power word wrong");
	a_online_pass: assert property (@(posedge clk_sys) disable iff (!rst_n)
		mode_ff == MPL_ONLINE |-> sub_out_ctl == cpu_out_ctl)
		else $error("online control not passed");
	a_in_pass: assert property (@(posedge clk_sys) disable iff (!rst_n)
		mode_ff == MPL_ONLINE |-> sub_in_ctl == cpu_in_ctl)
		else $error("online input control not passed");
	a_int_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
		mode_ff == MPL_OFF_IN |-> sub_in_ctl[sel_ff].int_enable)
		else $error("simulated interrupt permit low");
	a_out_block: assert property (@(posedge clk_sys) disable iff (!rst_n)
		mode_ff == MPL_OFF_OUT && !pulse_on |-> sub_out_ctl[sel_ff] == '0)
		else $error("computer output control not blocked");
	a_step_out: assert property (@(posedge clk_sys) disable iff (!rst_n)
		mode_ff == MPL_OFF_OUT && !continuous_mode && !pulse_on && step_rise |=> pulse_on)
		else $error("output step press gave no pulse");
	a_cont_ack: assert property (@(posedge clk_sys) disable iff (!rst_n)
		mode_ff == MPL_OFF_OUT && continuous_mode && !pulse_on
		&& rise(sub_out_req[sel_ff].out_req, out_req_ff[sel_ff].out_req) |=> sub_out_ctl[sel_ff].out_ack)
		else $error("output request not acknowledged");
	a_lamp_switch: assert property (@(posedge clk_sys) disable iff (!rst_n)
		1'b1 |=> lamp_switch == $past(op_switches))
		else $error("switch lamps wrong");
	a_lamp_in: assert property (@(posedge clk_sys) disable iff (!rst_n)
		mode_ff == MPL_OFF_IN |=> lamp_data == $past(sub_in_data[sel_ff]))
		else $error("input data lamps wrong");
	a_lamp_out: assert property (@(posedge clk_sys) disable iff (!rst_n)
		mode_ff == MPL_OFF_OUT |=> lamp_data == $past(sub_data))
		else $error("output data lamps wrong");
	a_power_block: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!input_power_ok |=> !power_irq)
		else $error("power word sent on bad input power");
endmodule

// ==== dv/mpl_sub_model.sv ====
// subunit model: raises requests, drops them once answered, shows input data
`timescale 1ns/1ps
module mpl_sub_model import mpl_pkg::*; (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [2:0] in_go,
	input wire logic [1:0] out_go,
	input wire mpl_in_ctl_t [2:0] sub_in_ctl,
	input wire mpl_out_ctl_t [2:0] sub_out_ctl,
	output logic [2:0] sub_in_req,
	output mpl_out_req_t [2:0] sub_out_req,
	output logic [2:0][29:0] sub_in_data
);
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			sub_in_data[i] = 30'h0ABC0000 + 30'(i + 1);
		end
	end
	always_ff @(posedge clk_sys) begin
		for (int i = 0; i < 3; i++) begin
			if (!rst_n || sub_in_ctl[i].ack) begin
				sub_in_req[i] <= 1'h0;
			end else if (in_go[i]) begin
				sub_in_req[i] <= 1'h1;
			end
		end
		sub_out_req[1:0] <= 4'h0;
		if (!rst_n || sub_out_ctl[2].out_ack) begin
			sub_out_req[2].out_req <= 1'h0;
		end else if (out_go[0]) begin
			sub_out_req[2].out_req <= 1'h1;
		end
		if (!rst_n || sub_out_ctl[2].cmd_strobe) begin
			sub_out_req[2].cmd_req <= 1'h0;
		end else if (out_go[1]) begin
			sub_out_req[2].cmd_req <= 1'h1;
		end
	end
endmodule

// ==== dv/tb_mpl_channel.sv ====
// testbench for the maintenance panel channel logic
`timescale 1ns/1ps
`include "mpl_map.svh"
module tb_mpl_channel import mpl_pkg::*;;
	localparam int PW = `MPL_PULSE_CYC;
	logic clk_sys, rst_n, off_in, off_out, on_req, cont, step, step_cmd, pwr_ok, irq, probe;
	logic [29:0] cpu_data, op_sw, sup_ok, sub_data, ext_data, lamp_data, lamp_sw, pw_word;
	logic [1:0] sel, out_go, lamp_rq, lamp_ct;
	logic [2:0] in_go, in_req;
	logic [2:0][29:0] in_data;
	mpl_out_ctl_t [2:0] cpu_oc, sub_oc;
	mpl_in_ctl_t [2:0] cpu_ic, sub_ic;
	mpl_out_req_t [2:0] out_req;
	mpl_mode_t mode;
	int failures, comparisons, cycles, psel;
	mpl_channel i_mpl_channel (.clk_sys(clk_sys), .rst_n(rst_n), .cpu_data(cpu_data), .cpu_out_ctl(cpu_oc),
		.cpu_in_ctl(cpu_ic), .sub_out_req(out_req), .sub_in_req(in_req), .sub_in_data(in_data),
		.offline_in_req(off_in), .offline_out_req(off_out), .online_req(on_req), .periph_sel(sel),
		.continuous_mode(cont), .step_switch(step), .step_cmd(step_cmd), .op_switches(op_sw),
		.supply_ok(sup_ok), .input_power_ok(pwr_ok), .sub_data(sub_data), .ext_data(ext_data),
		.sub_out_ctl(sub_oc), .sub_in_ctl(sub_ic), .lamp_data(lamp_data), .lamp_req(lamp_rq), .lamp_ctl(lamp_ct),
		.lamp_switch(lamp_sw), .mode(mode), .power_irq(irq), .power_word(pw_word));
	mpl_sub_model i_mpl_sub_model (.clk_sys(clk_sys), .rst_n(rst_n), .in_go(in_go), .out_go(out_go),
		.sub_in_ctl(sub_ic), .sub_out_ctl(sub_oc), .sub_in_req(in_req), .sub_out_req(out_req),
		.sub_in_data(in_data));
	always_comb begin
		case (psel)
			0: probe = sub_ic[1].ack;
			1: probe = sub_oc[2].out_ack;
			2: probe = sub_oc[2].cmd_strobe;
			default: probe = irq;
		endcase
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// counts high cycles of the probed output over ten cycles
	task automatic pulses(input int s, input int n);
		logic [31:0] c;
		c = 0;
		psel = s;
		repeat (10) begin
			@(negedge clk_sys);
			c += probe;
		end
		chk(c, n);
	endtask
	task automatic end_sim();
		if (failures == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	initial begin
		clk_sys = 1'h0;
		forever #2 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles >= 2000) begin
			failures++;
			end_sim();
		end
	end
	initial begin
		{rst_n, off_in, off_out, on_req, cont, step, step_cmd, sel, in_go, out_go, psel} = '0;
		{cpu_data, op_sw, cpu_oc, cpu_ic, failures, comparisons, cycles} = '0;
		sup_ok = 30'h3FFFFFFF;
		pwr_ok = 1'h1;
		repeat (5) @(negedge clk_sys);
		rst_n = 1'h1;
		cpu_data = 30'h2AAAAAAA;
		cpu_ic = 6'h2D;
		cpu_oc = 6'h1B;
		repeat (2) @(negedge clk_sys);
		chk(mode, MPL_ONLINE);
		chk(sub_data, 30'h2AAAAAAA);
		chk(ext_data, 30'h2AAAAAAA);
		chk(sub_ic, 6'h2D);
		chk(sub_oc, 6'h1B);
		chk(lamp_data, 30'h0ABC0001);
		{sel, off_in, cpu_ic} = {2'h1, 1'h1, 6'h3F};
		repeat (2) @(negedge clk_sys);
		chk(mode, MPL_OFF_IN);
		chk(sub_ic, 6'h37);
		chk(lamp_data, 30'h0ABC0002);
		chk(lamp_ct, 2'h1);
		cpu_ic = 6'h00;
		for (int k = 0; k < 2; k++) begin
			step = 1'h1;
			pulses(0, PW);
			step = 1'h0;
			@(negedge clk_sys);
		end
		cont = 1'h1;
		in_go = 3'h2;
		@(negedge clk_sys);
		in_go = 3'h0;
		pulses(0, PW);
		{off_in, off_out, sel, cont, op_sw, cpu_oc, cpu_ic} = {2'h1, 2'h2, 1'h0, 30'h15555555, 12'hFFF};
		repeat (2) @(negedge clk_sys);
		chk(mode, MPL_OFF_OUT);
		chk(sub_ic, 6'h3F);
		chk(sub_data, 30'h15555555);
		chk(lamp_sw, 30'h15555555);
		chk(ext_data, 30'h2AAAAAAA);
		chk(sub_oc, 6'h0F);
		cpu_oc = 6'h00;
		for (int k = 0; k < 2; k++) begin
			step_cmd = k[0];
			step = 1'h1;
			pulses(1 + k, PW);
			step = 1'h0;
			@(negedge clk_sys);
		end
		cont = 1'h1;
		for (int k = 0; k < 2; k++) begin
			out_go = 2'(1 << k);
			@(negedge clk_sys);
			out_go = 2'h0;
			pulses(1 + k, PW);
		end
		{cont, out_go} = 3'h3;
		@(negedge clk_sys);
		out_go = 2'h0;
		@(negedge clk_sys);
		chk(lamp_rq, 2'h3);
		chk(lamp_data, 30'h15555555);
		step = 1'h1;
		repeat (2) @(negedge clk_sys);
		chk(lamp_ct, 2'h1);
		step = 1'h0;
		repeat (3) @(negedge clk_sys);
		{on_req, off_out} = 2'h2;
		repeat (2) @(negedge clk_sys);
		chk(mode, MPL_ONLINE);
		sup_ok = 30'h3FFFFFFE;
		pulses(3, 1);
		chk(pw_word, 30'h3FFFFFFE);
		{pwr_ok, sup_ok} = {1'h0, 30'h3FFFFFFF};
		pulses(3, 0);
		pwr_ok = 1'h1;
		repeat (5) @(negedge clk_sys);
		sup_ok = 30'h3FFFFFFD;
		pulses(3, 1);
		end_sim();
	end
endmodule
